// File: dmau_map.svh
/*
  Offsets, field positions, reset values and write masks of the data-memory access unit.
  Assumes inclusion by bare name from the module and bench files.
*/
// Behaviour
// R1: lower 128 bytes: direct and indirect access
// R2: upper 128 RAM bytes only indirectly reachable
// R3: direct upper half selects special registers
// R4: lowest 32 bytes form four banks
// R5: register accesses use bank from status bits
// R6: bit addresses 00..7f map RAM bits
// R7: special registers at x0/x8 are bit-addressable
// R8: 1024-byte auxiliary RAM for external moves
// R9: addresses up to 0x03ff hit auxiliary RAM
// R10: addresses above 0x03ff go off-chip
// R11: disable bit set: auxiliary RAM never used
// R12: indirect register move ignores pointer high byte; code uses it while the disable bit is set
// R13: 64K external bus with latch and strobes
// R14: latch setup/hold equals field plus one
// R15: strobe width equals field plus one clocks
// R16: auxiliary RAM accesses ignore stretch settings
// R17: two data pointers chosen by select bit
// R18: status word flag bit positions
// R19: general flag two is free storage
// R20: address latched, then strobe, memory responds
`ifndef DMAU_MAP_SVH
`define DMAU_MAP_SVH
`define DMAU_ADDR_STRETCH 8'ha1
`define DMAU_ADDR_STATUS 8'hd0
`define DMAU_ADDR_AUXCTL 8'h8e
`define DMAU_ADDR_AUXCTL2 8'ha2
`define DMAU_ADDR_PTR_LOW 8'h82
`define DMAU_ADDR_PTR_HIGH 8'h83
`define DMAU_RST_STRETCH 8'h23
`define DMAU_RST_STATUS 8'h00
`define DMAU_RST_AUXCTL 8'h00
`define DMAU_RST_AUXCTL2 8'h00
`define DMAU_STRETCH_WMASK 8'h37
`define DMAU_AUXCTL2_WMASK 8'h09
`define DMAU_BIT_CARRY 7
`define DMAU_BIT_HALF_CARRY 6
`define DMAU_BIT_USER0 5
`define DMAU_BIT_BANK_HI 4
`define DMAU_BIT_BANK_LO 3
`define DMAU_BIT_OVERFLOW 2
`define DMAU_BIT_USER1 1
`define DMAU_BIT_PARITY 0
`define DMAU_BIT_AUX_DISABLE 1
`define DMAU_BIT_PTR_SELECT 0
`define DMAU_BIT_GENERAL_FLAG 3
`define DMAU_LATCH_LSB 4
`define DMAU_STROBE_LSB 0
`define DMAU_AUX_TOP 16'h03ff
`endif

// File: dmau_pkg.sv
/*
  Types of the data-memory access unit.
  Assumes dmau_map.svh is on the include path.
*/
package dmau_pkg;
  typedef enum logic [1:0] {
    DMAU_DIRECT,
    DMAU_INDIRECT,
    DMAU_REGISTER,
    DMAU_BIT
  } dmau_mode_t;

  typedef struct packed {
    logic req;
    logic wr;
    dmau_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmau_int_req_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic use_ptr;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
  } dmau_ext_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic addr_oe_n;
    logic data_oe_n;
    logic latch;
    logic wr_n;
    logic rd_n;
  } dmau_bus_t;

  typedef enum logic [2:0] {
    DMAU_IDLE,
    DMAU_SETUP,
    DMAU_HOLD,
    DMAU_STROBE,
    DMAU_CAPTURE
  } dmau_state_t;
endpackage

// File: dmau_ext_bus.sv
/*
  External bus sequencer: address latch, then read or write strobe.
  Assumes requests arrive only while idle_out is high; read data pin synchronised here.
*/
`timescale 1ns/1ps
`include "dmau_map.svh"
module dmau_ext_bus (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic wr_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [1:0] latch_field_in,
  input wire logic [2:0] strobe_field_in,
  input wire logic [7:0] pin_data_in,
  output logic idle_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output dmau_pkg::dmau_bus_t bus_out
);
  typedef struct packed {
    dmau_pkg::dmau_state_t st;
    logic [2:0] cnt;
    logic wr;
    logic done;
    logic [7:0] rdata;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [1:0] lat;
    logic [2:0] stb;
    dmau_pkg::dmau_bus_t bus;
  } dmau_xb_t;

  dmau_xb_t r_q;
  dmau_xb_t r_d;

  // ==========================================================
  // sequencer
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_data_in;
    r_d.s2 = r_q.s1;
    r_d.done = 1'b0;
    case (r_q.st)
      dmau_pkg::DMAU_IDLE: begin
        if (start_in) begin
          r_d.st = dmau_pkg::DMAU_SETUP;
          r_d.cnt = 3'h0;
          r_d.wr = wr_in;
          r_d.lat = latch_field_in;
          r_d.stb = strobe_field_in;
          r_d.bus.addr = addr_in; // R13
          r_d.bus.wdata = wdata_in;
          r_d.bus.addr_oe_n = 1'b0;
          r_d.bus.latch = 1'b1;
        end
      end
      dmau_pkg::DMAU_SETUP: begin
        // low address stands field+1 clocks before latch falls
        if (r_q.cnt == {1'b0, r_q.lat}) begin // R14
          r_d.st = dmau_pkg::DMAU_HOLD;
          r_d.cnt = 3'h0;
          r_d.bus.latch = 1'b0; // R20
        end else begin
          r_d.cnt = r_q.cnt + 3'h1;
        end
      end
      dmau_pkg::DMAU_HOLD: begin
        if (r_q.cnt == {1'b0, r_q.lat}) begin // R14
          r_d.st = dmau_pkg::DMAU_STROBE;
          r_d.cnt = 3'h0;
          r_d.bus.data_oe_n = ~r_q.wr;
          r_d.bus.wr_n = ~r_q.wr; // R20
          r_d.bus.rd_n = r_q.wr;
        end else begin
          r_d.cnt = r_q.cnt + 3'h1;
        end
      end
      dmau_pkg::DMAU_STROBE: begin
        if (r_q.cnt == r_q.stb) begin // R15
          r_d.st = dmau_pkg::DMAU_CAPTURE;
          r_d.cnt = 3'h0;
          r_d.bus.wr_n = 1'b1;
          r_d.bus.rd_n = 1'b1;
          r_d.bus.addr_oe_n = 1'b1;
          r_d.bus.data_oe_n = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt + 3'h1;
        end
      end
      dmau_pkg::DMAU_CAPTURE: begin
        // pins sampled at the strobe's last edge need two clocks through the sync flops
        if (r_q.cnt == 3'h1) begin // R20
          r_d.st = dmau_pkg::DMAU_IDLE;
          r_d.done = 1'b1;
          if (!r_q.wr) begin
            r_d.rdata = r_q.s2;
          end
        end else begin
          r_d.cnt = r_q.cnt + 3'h1;
        end
      end
      default: begin
        r_d.st = dmau_pkg::DMAU_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_q <= '0;
      r_q.bus.addr_oe_n <= 1'b1;
      r_q.bus.data_oe_n <= 1'b1;
      r_q.bus.wr_n <= 1'b1;
      r_q.bus.rd_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign idle_out = (r_q.st == dmau_pkg::DMAU_IDLE);
  assign done_out = r_q.done;
  assign rdata_out = r_q.rdata;
  assign bus_out = r_q.bus;
endmodule

// File: dmau_top.sv
/*
  Data-memory access unit: scratch-pad RAM, banked registers, bit access, special registers,
  auxiliary RAM and the external data bus.
  Assumes the core holds each request for one cycle and waits for the done pulse.
*/
`timescale 1ns/1ps
`include "dmau_map.svh"
module dmau_top #(
  parameter int AUX_BYTES = 1024
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire dmau_pkg::dmau_int_req_t int_req_in,
  input wire dmau_pkg::dmau_ext_req_t ext_req_in,
  input wire logic [7:0] pin_data_in,
  output logic int_done_out,
  output logic [7:0] int_rdata_out,
  output logic ext_done_out,
  output logic ext_busy_out,
  output logic [7:0] ext_rdata_out,
  output logic [7:0] status_out,
  output logic [15:0] pointer_out,
  output dmau_pkg::dmau_bus_t bus_out
);
  // aux address decode is fixed at ten bits
  if (AUX_BYTES != 1024) begin : g_size_check
    $error("aux RAM size must be 1024");
  end

  typedef struct packed {
    logic [7:0] stretch;
    logic [7:0] status;
    logic [7:0] auxctl;
    logic [7:0] auxctl2;
    logic [1:0][15:0] ptr;
    logic int_done;
    logic [7:0] int_rdata;
    logic aux_done;
    logic [7:0] aux_rdata;
  } dmau_state_regs_t;

  dmau_state_regs_t r_q;
  dmau_state_regs_t r_d;
  logic [7:0] iram [0:255];
  logic [7:0] xram [0:AUX_BYTES-1];

  // ==========================================================
  // address decode helpers
  function automatic logic is_bit_sfr(input logic [7:0] a);
    is_bit_sfr = a[7] && (a[2:0] == 3'h0); // R7
  endfunction

  // ==========================================================
  // internal access resolution
  logic [7:0] byte_addr;
  logic [2:0] bit_pos;
  logic to_sfr;
  logic bit_ok;
  always_comb begin
    byte_addr = int_req_in.addr;
    bit_pos = 3'h0;
    to_sfr = 1'b0;
    bit_ok = 1'b1;
    case (int_req_in.mode)
      dmau_pkg::DMAU_DIRECT: begin
        to_sfr = int_req_in.addr[7]; // R1 R3
      end
      dmau_pkg::DMAU_INDIRECT: begin
        to_sfr = 1'b0; // R2
      end
      dmau_pkg::DMAU_REGISTER: begin
        byte_addr = {3'h0, r_q.status[`DMAU_BIT_BANK_HI], r_q.status[`DMAU_BIT_BANK_LO],
                     int_req_in.addr[2:0]}; // R4 R5
      end
      dmau_pkg::DMAU_BIT: begin
        bit_pos = int_req_in.addr[2:0];
        if (int_req_in.addr[7]) begin
          byte_addr = {int_req_in.addr[7:3], 3'h0};
          to_sfr = 1'b1;
          bit_ok = is_bit_sfr(byte_addr); // R7
        end else begin
          byte_addr = {4'h2, int_req_in.addr[6:3]}; // R6
        end
      end
      default: begin
        byte_addr = int_req_in.addr;
      end
    endcase
  end

  function automatic logic [7:0] sfr_read(input dmau_state_regs_t s, input logic [7:0] a);
    logic sel;
    sel = s.auxctl2[`DMAU_BIT_PTR_SELECT];
    case (a)
      `DMAU_ADDR_STRETCH: sfr_read = s.stretch & `DMAU_STRETCH_WMASK;
      `DMAU_ADDR_STATUS: sfr_read = s.status;
      `DMAU_ADDR_AUXCTL: sfr_read = s.auxctl;
      `DMAU_ADDR_AUXCTL2: sfr_read = s.auxctl2 & `DMAU_AUXCTL2_WMASK;
      `DMAU_ADDR_PTR_LOW: sfr_read = s.ptr[sel][7:0]; // R17
      `DMAU_ADDR_PTR_HIGH: sfr_read = s.ptr[sel][15:8];
      default: sfr_read = 8'h00;
    endcase
  endfunction

  logic [7:0] cur_byte;
  always_comb begin
    cur_byte = to_sfr ? sfr_read(r_q, byte_addr) : iram[byte_addr];
  end

  // ==========================================================
  // external move routing
  logic ptr_sel;
  logic [15:0] ext_addr;
  logic aux_hit;
  logic bus_idle;
  logic bus_done;
  logic [7:0] bus_rdata;
  logic bus_start;
  always_comb begin
    ptr_sel = r_q.auxctl2[`DMAU_BIT_PTR_SELECT];
    if (ext_req_in.use_ptr) begin
      ext_addr = r_q.ptr[ptr_sel]; // R8
    end else if (!r_q.auxctl[`DMAU_BIT_AUX_DISABLE]) begin
      ext_addr = {8'h00, ext_req_in.reg_addr}; // R12
    end else begin
      ext_addr = {r_q.ptr[ptr_sel][15:8], ext_req_in.reg_addr};
    end
    aux_hit = !r_q.auxctl[`DMAU_BIT_AUX_DISABLE] // R11
              && (ext_addr <= `DMAU_AUX_TOP); // R9 R10
    bus_start = ext_req_in.req && !aux_hit && bus_idle;
  end

  // ==========================================================
  // register file and internal RAM update
  always_comb begin
    logic [7:0] wb;
    logic [7:0] wv;
    logic sel;
    wb = 8'h00;
    wv = 8'h00;
    sel = r_q.auxctl2[`DMAU_BIT_PTR_SELECT];
    r_d = r_q;
    r_d.int_done = 1'b0;
    r_d.aux_done = 1'b0;
    if (int_req_in.req) begin
      r_d.int_done = 1'b1;
      if (int_req_in.mode == dmau_pkg::DMAU_BIT) begin
        r_d.int_rdata = {7'h00, cur_byte[bit_pos] & bit_ok};
      end else begin
        r_d.int_rdata = cur_byte;
      end
      if (int_req_in.wr && to_sfr && bit_ok) begin
        wv = cur_byte;
        if (int_req_in.mode == dmau_pkg::DMAU_BIT) begin
          wv[bit_pos] = int_req_in.wdata[0];
        end else begin
          wv = int_req_in.wdata;
        end
        wb = byte_addr;
        case (wb)
          `DMAU_ADDR_STRETCH: r_d.stretch = wv & `DMAU_STRETCH_WMASK; // R14 R15
          `DMAU_ADDR_STATUS: r_d.status = wv; // R18
          `DMAU_ADDR_AUXCTL: r_d.auxctl = wv;
          `DMAU_ADDR_AUXCTL2: r_d.auxctl2 = wv & `DMAU_AUXCTL2_WMASK; // R19
          `DMAU_ADDR_PTR_LOW: r_d.ptr[sel][7:0] = wv; // R17
          `DMAU_ADDR_PTR_HIGH: r_d.ptr[sel][15:8] = wv;
          default: r_d.stretch = r_q.stretch;
        endcase
      end
    end
    if (ext_req_in.req && aux_hit) begin
      // one-cycle answer, no latch or strobe stretching
      r_d.aux_done = 1'b1; // R16
      r_d.aux_rdata = xram[ext_addr[9:0]];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_q <= '0;
      r_q.stretch <= `DMAU_RST_STRETCH;
      r_q.status <= `DMAU_RST_STATUS;
      r_q.auxctl <= `DMAU_RST_AUXCTL;
      r_q.auxctl2 <= `DMAU_RST_AUXCTL2;
    end else begin
      r_q <= r_d;
    end
  end

  // memories carry no reset; contents undefined after power-up
  logic [7:0] wbit_val;
  always_comb begin
    wbit_val = cur_byte;
    wbit_val[bit_pos] = int_req_in.wdata[0];
  end

  always_ff @(posedge ref_clk_in) begin
    if (int_req_in.req && int_req_in.wr && !to_sfr) begin
      if (int_req_in.mode == dmau_pkg::DMAU_BIT) begin
        iram[byte_addr] <= wbit_val; // R6
      end else begin
        iram[byte_addr] <= int_req_in.wdata; // R1 R2
      end
    end
    if (ext_req_in.req && aux_hit && ext_req_in.wr) begin
      xram[ext_addr[9:0]] <= ext_req_in.wdata; // R8
    end
  end

  // ==========================================================
  // external bus
  dmau_ext_bus u_bus (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(bus_start), // R10
    .wr_in(ext_req_in.wr),
    .addr_in(ext_addr),
    .wdata_in(ext_req_in.wdata),
    .latch_field_in(r_q.stretch[`DMAU_LATCH_LSB +: 2]), // R14
    .strobe_field_in(r_q.stretch[`DMAU_STROBE_LSB +: 3]), // R15
    .pin_data_in(pin_data_in),
    .idle_out(bus_idle),
    .done_out(bus_done),
    .rdata_out(bus_rdata),
    .bus_out(bus_out)
  );

  assign int_done_out = r_q.int_done;
  assign int_rdata_out = r_q.int_rdata;
  assign ext_done_out = r_q.aux_done | bus_done;
  assign ext_busy_out = !bus_idle;
  assign ext_rdata_out = r_q.aux_done ? r_q.aux_rdata : bus_rdata;
  assign status_out = r_q.status;
  assign pointer_out = r_q.ptr[r_q.auxctl2[`DMAU_BIT_PTR_SELECT]];
endmodule

// File: dmau_top_properties.sv
/* Port assertions for the data-memory access unit.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
module dmau_top_properties #(
  parameter int AUX_BYTES = 1024
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire dmau_pkg::dmau_int_req_t int_req_in,
  input wire dmau_pkg::dmau_ext_req_t ext_req_in,
  input wire logic [7:0] pin_data_in,
  input wire logic int_done_out,
  input wire logic [7:0] int_rdata_out,
  input wire logic ext_done_out,
  input wire logic ext_busy_out,
  input wire logic [7:0] ext_rdata_out,
  input wire logic [7:0] status_out,
  input wire logic [15:0] pointer_out,
  input wire dmau_pkg::dmau_bus_t bus_out
);
  // ====
  // run-length counters
  logic [3:0] lat_q;
  logic [3:0] stb_q;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lat_q <= 4'h0;
      stb_q <= 4'h0;
    end else begin
      lat_q <= bus_out.latch ? lat_q + 4'h1 : 4'h0;
      stb_q <= (!bus_out.rd_n || !bus_out.wr_n) ? stb_q + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_latch_drop;
    bus_out.latch ##1 !bus_out.latch;
  endsequence
  sequence s_strobe_end;
    (!bus_out.rd_n || !bus_out.wr_n) ##1 (bus_out.rd_n && bus_out.wr_n);
  endsequence
  // ====
  // properties
  a_int_answer: assert property (int_req_in.req |=> int_done_out)
    else $error("internal access not answered");
  a_int_no_spurious: assert property (int_done_out |-> $past(int_req_in.req))
    else $error("internal done without request");
  a_latch_width: assert property (lat_q <= 4'h4)
    else $error("latch high too long");
  a_strobe_width: assert property (stb_q <= 4'h8)
    else $error("strobe low too long");
  a_addr_hold: assert property (s_latch_drop |-> !bus_out.addr_oe_n && $stable(bus_out.addr))
    else $error("address not held after latch fall");
  a_strobe_after_latch: assert property (($fell(bus_out.rd_n) || $fell(bus_out.wr_n)) |->
    !bus_out.latch && !$past(bus_out.latch))
    else $error("strobe overlaps latch");
  a_done_on_release: assert property (s_strobe_end |-> ##2 ext_done_out)
    else $error("no done at strobe release");
  a_write_drives: assert property (!bus_out.wr_n |-> !bus_out.data_oe_n)
    else $error("write strobe without data drive");
  a_read_floats: assert property (!bus_out.rd_n |-> bus_out.data_oe_n && bus_out.wr_n)
    else $error("data driven during read");
  a_idle_quiet: assert property (!ext_busy_out |->
    bus_out.rd_n && bus_out.wr_n && !bus_out.latch)
    else $error("bus active while idle");
endmodule

// File: dmau_ext_ram.sv
/* External data RAM model on the latched bus.
   Assumes bus_in from dmau_top; data_out feeds its data pins. */
`timescale 1ns/1ps
module dmau_ext_ram (
  input wire logic clk_in,
  input wire dmau_pkg::dmau_bus_t bus_in,
  output logic [7:0] data_out
);
  logic [7:0] mem_q [0:255];
  logic [15:0] addr_q;
  logic [7:0] idle_q = 8'h5a;
  always @(posedge clk_in) begin
    // released pins never show a stable old value
    idle_q <= ~idle_q;
    if (bus_in.latch) addr_q <= bus_in.addr;
    if (!bus_in.wr_n) mem_q[addr_q[7:0]] <= bus_in.wdata;
  end
  assign data_out = bus_in.rd_n ? idle_q : mem_q[addr_q[7:0]];
endmodule

// File: data_memory_access_unit_bench.sv
/* Self-checking bench for dmau_top with the external RAM model.
   Assumes package, header and design compiled first. */
`timescale 1ns/1ps
`include "dmau_map.svh"
module data_memory_access_unit_bench;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  dmau_pkg::dmau_int_req_t int_req = '0;
  dmau_pkg::dmau_ext_req_t ext_req = '0;
  dmau_pkg::dmau_bus_t bus;
  logic [7:0] pin_data, int_rdata, ext_rdata, status, rd;
  logic int_done, ext_done, ext_busy;
  logic [15:0] pointer;
  int bad_count = 0;
  int num_checks = 0;
  int nlat, nstb, nwait;
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  dmau_top u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .int_req_in(int_req),
    .ext_req_in(ext_req), .pin_data_in(pin_data), .int_done_out(int_done),
    .int_rdata_out(int_rdata), .ext_done_out(ext_done), .ext_busy_out(ext_busy),
    .ext_rdata_out(ext_rdata), .status_out(status), .pointer_out(pointer), .bus_out(bus));
  dmau_ext_ram u_ram (.clk_in(ref_clk_in), .bus_in(bus), .data_out(pin_data));
  // ====
  // shared tasks
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic int_op(input logic wr, input dmau_pkg::dmau_mode_t md, input logic [7:0] a, d);
    @(posedge ref_clk_in);
    int_req <= '{req: 1'b1, wr: wr, mode: md, addr: a, wdata: d};
    @(posedge ref_clk_in);
    int_req.req <= 1'b0;
    #1;
    check("int done", 16'h1, {15'h0, int_done});
    rd = int_rdata;
  endtask
  task automatic dir_wr(input logic [7:0] a, d);
    int_op(1'b1, dmau_pkg::DMAU_DIRECT, a, d);
  endtask
  task automatic rd_chk(input dmau_pkg::dmau_mode_t md, input logic [7:0] a, exp);
    int_op(1'b0, md, a, 8'h00);
    check("internal read", {8'h0, exp}, {8'h0, rd});
  endtask
  task automatic ext_op(input logic wr, ptr, input logic [7:0] ra, d);
    @(posedge ref_clk_in);
    ext_req <= '{req: 1'b1, wr: wr, use_ptr: ptr, reg_addr: ra, wdata: d};
    @(posedge ref_clk_in);
    ext_req.req <= 1'b0;
    #1;
    nlat = 0;
    nstb = 0;
    for (nwait = 0; ext_done !== 1'b1; nwait++) begin
      if (nwait == 60) begin
        bad_count++;
        stop_test();
      end
      nlat += int'(bus.latch === 1'b1);
      nstb += int'(bus.rd_n === 1'b0 || bus.wr_n === 1'b0);
      @(posedge ref_clk_in);
      #1;
    end
    rd = ext_rdata;
  endtask
  // ====
  // scenarios
  task automatic t_regs();
    check("pointer", 16'h0, pointer);
    rd_chk(dmau_pkg::DMAU_DIRECT, `DMAU_ADDR_STRETCH, 8'h23);
    dir_wr(`DMAU_ADDR_AUXCTL2, 8'hff);
    rd_chk(dmau_pkg::DMAU_DIRECT, `DMAU_ADDR_AUXCTL2, 8'h09);
    dir_wr(`DMAU_ADDR_PTR_HIGH, 8'h04);
    check("pointer", 16'h0400, pointer);
    dir_wr(`DMAU_ADDR_AUXCTL2, 8'h08);
    check("pointer", 16'h0000, pointer);
  endtask
  task automatic t_spaces();
    dir_wr(8'h40, 8'h11);
    rd_chk(dmau_pkg::DMAU_INDIRECT, 8'h40, 8'h11);
    int_op(1'b1, dmau_pkg::DMAU_INDIRECT, 8'ha1, 8'h5c);
    rd_chk(dmau_pkg::DMAU_DIRECT, 8'ha1, 8'h23);
    rd_chk(dmau_pkg::DMAU_INDIRECT, 8'ha1, 8'h5c);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      dir_wr(`DMAU_ADDR_STATUS, 8'(b << 3));
      int_op(1'b1, dmau_pkg::DMAU_REGISTER, 8'h05, 8'(b) + 8'h30);
    end
    for (int b = 0; b < 4; b++) rd_chk(dmau_pkg::DMAU_DIRECT, 8'(8 * b + 5), 8'(b) + 8'h30);
    rd_chk(dmau_pkg::DMAU_REGISTER, 8'h05, 8'h33);
    dir_wr(`DMAU_ADDR_STATUS, 8'he6);
    check("status flags", 16'h00e6, {8'h0, status & 8'hfe});
    dir_wr(`DMAU_ADDR_STATUS, 8'h00);
  endtask
  task automatic t_bits();
    dir_wr(8'h21, 8'h00);
    dir_wr(8'h2f, 8'h00);
    int_op(1'b1, dmau_pkg::DMAU_BIT, 8'h0b, 8'h01);
    int_op(1'b1, dmau_pkg::DMAU_BIT, 8'h7f, 8'h01);
    rd_chk(dmau_pkg::DMAU_DIRECT, 8'h21, 8'h08);
    rd_chk(dmau_pkg::DMAU_DIRECT, 8'h2f, 8'h80);
    rd_chk(dmau_pkg::DMAU_BIT, 8'h0b, 8'h01);
    int_op(1'b1, dmau_pkg::DMAU_BIT, 8'hd5, 8'h01);
    check("status bit", 16'h0020, {8'h0, status & 8'h20});
    rd_chk(dmau_pkg::DMAU_BIT, 8'hd5, 8'h01);
  endtask
  task automatic t_aux();
    // longest stretch set: aux path must not care
    dir_wr(`DMAU_ADDR_STRETCH, 8'h37);
    dir_wr(`DMAU_ADDR_PTR_LOW, 8'hff);
    dir_wr(`DMAU_ADDR_PTR_HIGH, 8'h03);
    ext_op(1'b1, 1'b1, 8'h00, 8'ha5);
    check("aux cycles", 16'h0, 16'(nwait));
    ext_op(1'b0, 1'b1, 8'h00, 8'h00);
    check("aux data", 16'h00a5, {8'h0, rd});
    dir_wr(`DMAU_ADDR_PTR_HIGH, 8'h05);
    ext_op(1'b1, 1'b0, 8'h10, 8'h3c);
    check("aux cycles", 16'h0, 16'(nwait));
    dir_wr(`DMAU_ADDR_PTR_LOW, 8'h10);
    dir_wr(`DMAU_ADDR_PTR_HIGH, 8'h00);
    ext_op(1'b0, 1'b1, 8'h00, 8'h00);
    check("aux data", 16'h003c, {8'h0, rd});
    dir_wr(`DMAU_ADDR_AUXCTL, 8'h02);
    ext_op(1'b1, 1'b1, 8'h00, 8'h77);
    check("bus used", 16'h0001, 16'(nlat != 0));
    dir_wr(`DMAU_ADDR_AUXCTL, 8'h00);
    ext_op(1'b0, 1'b1, 8'h00, 8'h00);
    check("aux data", 16'h003c, {8'h0, rd});
  endtask
  task automatic t_bus();
    logic [7:0] cfg [3] = '{8'h00, 8'h23, 8'h37};
    dir_wr(`DMAU_ADDR_PTR_LOW, 8'h00);
    dir_wr(`DMAU_ADDR_PTR_HIGH, 8'h04);
    foreach (cfg[i]) begin
      dir_wr(`DMAU_ADDR_STRETCH, cfg[i]);
      ext_op(1'b1, 1'b1, 8'h00, 8'(i) + 8'h60);
      check("latch cycles", 16'(cfg[i][5:4]) + 16'h1, 16'(nlat));
      check("strobe cycles", 16'(cfg[i][2:0]) + 16'h1, 16'(nstb));
      ext_op(1'b0, 1'b1, 8'h00, 8'h00);
      check("bus read", {8'h0, 8'(i) + 8'h60}, {8'h0, rd});
      check("bus busy", 16'h0, {15'h0, ext_busy});
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_spaces();
    t_banks();
    t_bits();
    t_aux();
    t_bus();
    stop_test();
  end
endmodule
bind dmau_top dmau_top_properties #(.AUX_BYTES(AUX_BYTES)) u_props (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .int_req_in(int_req_in),
  .ext_req_in(ext_req_in), .pin_data_in(pin_data_in), .int_done_out(int_done_out),
  .int_rdata_out(int_rdata_out), .ext_done_out(ext_done_out), .ext_busy_out(ext_busy_out),
  .ext_rdata_out(ext_rdata_out), .status_out(status_out), .pointer_out(pointer_out),
  .bus_out(bus_out));
